// ===== hw/tmr_pkg.sv
package tmr_pkg;
    // register map: idx is the word index, byte address = 4 * idx
    localparam int ADDR_W = 18;
    localparam logic [15:0] IDX_CLKSEL0 = 16'hff6a;
    localparam logic [15:0] IDX_CLKSEL1 = 16'hff8c;
    localparam logic [15:0] IDX_CMP = 16'hff70;
    localparam logic [15:0] IDX_CTRL = 16'hff71;
    localparam logic [15:0] IDX_COUNT = 16'hff72;
    localparam logic [15:0] IDX_STATUS = 16'hff73;
    localparam logic [15:0] IDX_MASK = 16'hff74;
    // control register fields
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_MODE_BIT = 6;
    localparam int CTRL_LVS_BIT = 3;
    localparam int CTRL_LVR_BIT = 2;
    localparam int CTRL_INV_BIT = 1;
    localparam int CTRL_OE_BIT = 0;
    localparam int STS_MATCH_BIT = 0;
    // reset values
    localparam logic [7:0] RST_CMP = 8'h00;
    localparam logic [2:0] RST_CLKSEL = 3'h0;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] COUNT_TOP = 8'hff;
    // clock select codes
    localparam int CLKSEL_W = 3;
    localparam logic [2:0] CODE_FALL = 3'h0;
    localparam logic [2:0] CODE_RISE = 3'h1;
    localparam logic [2:0] CODE_DIV1 = 3'h2;
    localparam logic [2:0] CODE_DIV2 = 3'h3;
    localparam int PRE_W = 13;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SEL_NONE = 3'b000,
        SEL_CLK = 3'b001,
        SEL_CMP = 3'b010,
        SEL_CTRL = 3'b011,
        SEL_CNT = 3'b100,
        SEL_STS = 3'b101,
        SEL_MASK = 3'b110
    } tmr_sel_t;

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } tmr_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tmr_axi_rsp_t;
endpackage

// ===== hw/tmr_timer8.sv
// What this block does
// - outside PWM mode the counter is compared with the compare value and a match raises match_irq.
// - in PWM mode a match drives the output pin inactive and raises no match_irq.
// - the compare value accepts every code from 00h to ffh.
// - reset loads the compare value with zero.
// - the compare value is read and written only as a whole byte.
// - bits 2..0 of clock select pick the source; code 0 is the falling and 1 the rising input edge.
// - for unit 0 codes 2..7 divide the peripheral clock by 1, 2, 4, 64, 256 and 8192.
// - for unit 1 codes 2..7 divide the peripheral clock by 1, 2, 16, 64, 256 and 4096.
// - reset loads clock select with zero, the falling input edge.
// - clock select is written only as a whole byte, through the low byte lane; every such write loads all three bits.
// - the counter steps on each count clock and clears on reset, on disable and on a clear-mode match.
// - mode select zero is clear-and-start on match, one is free-running PWM.
`timescale 1ns/1ps
module tmr_timer8 #(
    parameter int UNIT = 0
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // register bus
    input wire tmr_pkg::tmr_axi_req_t axi_req_i,
    output tmr_pkg::tmr_axi_rsp_t axi_rsp_o,
    // pins
    input wire logic event_in_pin_i,
    output logic timer_out_pin_o,
    // interrupt
    output logic match_irq_o
);
    import tmr_pkg::*;

    logic [2:0] clk_sel_ff;
    logic [7:0] compare_value_ff;
    logic count_enable_ff, mode_select_ff, inv_ff, oe_ff;
    logic [7:0] count_value_ff;
    logic [PRE_W-1:0] pre_ff;
    logic ev_s1_ff, ev_s2_ff, ev_s3_ff;
    logic tff_ff, pwm_act_ff, pin_ff;
    logic sts_ff, mask_ff, irq_ff;
    logic aw_held_ff, w_held_ff, awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [ADDR_W-1:0] aw_addr_ff;
    logic [31:0] w_data_ff, rdata_ff;
    logic [3:0] w_strb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    tmr_sel_t rsel_ff;
    logic sel_tick, eq, match_evt, do_wr, rd_take, wr_byte0;
    logic nxt_aw_held, nxt_w_held, nxt_rvalid;
    tmr_sel_t wsel, rsel;
    logic [PRE_W-1:0] tap_mask;

    function automatic tmr_sel_t dec_addr(input logic [ADDR_W-1:0] a);
        logic [15:0] idx;
        idx = a[ADDR_W-1:2];
        if (idx == (UNIT == 0 ? IDX_CLKSEL0 : IDX_CLKSEL1)) begin
            dec_addr = SEL_CLK;
        end else if (idx == IDX_CMP) begin
            dec_addr = SEL_CMP;
        end else if (idx == IDX_CTRL) begin
            dec_addr = SEL_CTRL;
        end else if (idx == IDX_COUNT) begin
            dec_addr = SEL_CNT;
        end else if (idx == IDX_STATUS) begin
            dec_addr = SEL_STS;
        end else if (idx == IDX_MASK) begin
            dec_addr = SEL_MASK;
        end else begin
            dec_addr = SEL_NONE;
        end
    endfunction

    // log2 of the divider for codes 2..7, per unit
    function automatic logic [3:0] tap_shift(input logic [2:0] code);
        case (code)
            3'h2: tap_shift = 4'h0;
            3'h3: tap_shift = 4'h1;
            3'h4: tap_shift = (UNIT == 0) ? 4'h2 : 4'h4;
            3'h5: tap_shift = 4'h6;
            3'h6: tap_shift = 4'h8;
            3'h7: tap_shift = (UNIT == 0) ? 4'hd : 4'hc;
            default: tap_shift = 4'h0;
        endcase
    endfunction

    // bus handshake bookkeeping
    assign do_wr = aw_held_ff & w_held_ff & ~bvalid_ff;
    assign rd_take = axi_req_i.arvalid & arready_ff;
    assign nxt_aw_held = (aw_held_ff & ~do_wr) | (axi_req_i.awvalid & awready_ff);
    assign nxt_w_held = (w_held_ff & ~do_wr) | (axi_req_i.wvalid & wready_ff);
    assign nxt_rvalid = rd_take | (rvalid_ff & ~axi_req_i.rready);
    assign wsel = dec_addr(aw_addr_ff);
    assign rsel = dec_addr(axi_req_i.araddr);
    assign wr_byte0 = do_wr & w_strb_ff[0];

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            aw_addr_ff <= '0;
            w_data_ff <= 32'h0;
            w_strb_ff <= 4'h0;
        end else begin
            aw_held_ff <= nxt_aw_held;
            w_held_ff <= nxt_w_held;
            awready_ff <= ~nxt_aw_held;
            wready_ff <= ~nxt_w_held;
            if (axi_req_i.awvalid && awready_ff) begin
                aw_addr_ff <= axi_req_i.awaddr;
            end
            if (axi_req_i.wvalid && wready_ff) begin
                w_data_ff <= axi_req_i.wdata;
                w_strb_ff <= axi_req_i.wstrb;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (do_wr) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (axi_req_i.bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= RESP_OKAY;
            rsel_ff <= SEL_NONE;
        end else begin
            rvalid_ff <= nxt_rvalid;
            arready_ff <= ~nxt_rvalid;
            if (rd_take) begin
                rsel_ff <= rsel;
                rresp_ff <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
                case (rsel)
                    SEL_CLK: rdata_ff <= {29'h0, clk_sel_ff};
                    SEL_CMP: rdata_ff <= {24'h0, compare_value_ff};
                    // level-set bits are write-only and read back as zero
                    SEL_CTRL: rdata_ff <= {24'h0, count_enable_ff, mode_select_ff, 4'h0,
                                           inv_ff, oe_ff};
                    SEL_CNT: rdata_ff <= {24'h0, count_value_ff};
                    SEL_STS: rdata_ff <= {31'h0, sts_ff};
                    SEL_MASK: rdata_ff <= {31'h0, mask_ff};
                    default: rdata_ff <= 32'h0;
                endcase
            end
        end
    end

    assign axi_rsp_o = '{awready: awready_ff, wready: wready_ff, bvalid: bvalid_ff,
                         bresp: bresp_ff, arready: arready_ff, rvalid: rvalid_ff,
                         rdata: rdata_ff, rresp: rresp_ff};

    // register writes; only the low byte lane carries data
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            clk_sel_ff <= RST_CLKSEL;
            compare_value_ff <= RST_CMP;
            {count_enable_ff, mode_select_ff, inv_ff, oe_ff} <= 4'h0;
            mask_ff <= 1'b0;
        end else if (wr_byte0) begin
            case (wsel)
                SEL_CLK: clk_sel_ff <= w_data_ff[CLKSEL_W-1:0];
                SEL_CMP: compare_value_ff <= w_data_ff[7:0];
                SEL_CTRL: begin
                    count_enable_ff <= w_data_ff[CTRL_EN_BIT];
                    mode_select_ff <= w_data_ff[CTRL_MODE_BIT];
                    inv_ff <= w_data_ff[CTRL_INV_BIT];
                    oe_ff <= w_data_ff[CTRL_OE_BIT];
                end
                SEL_MASK: mask_ff <= w_data_ff[STS_MATCH_BIT];
                default: mask_ff <= mask_ff;
            endcase
        end
    end

    // free prescaler; a tap fires when its low bits are all ones
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pre_ff <= '0;
        end else begin
            pre_ff <= pre_ff + 1'b1;
        end
    end

    // first stage feeds only the second; edges come from stages two and three
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            {ev_s1_ff, ev_s2_ff, ev_s3_ff} <= 3'h0;
        end else begin
            ev_s1_ff <= event_in_pin_i;
            ev_s2_ff <= ev_s1_ff;
            ev_s3_ff <= ev_s2_ff;
        end
    end

    always_comb begin
        tap_mask = PRE_W'((14'h1 << tap_shift(clk_sel_ff)) - 14'h1);
        case (clk_sel_ff)
            CODE_FALL: sel_tick = ~ev_s2_ff & ev_s3_ff;
            CODE_RISE: sel_tick = ev_s2_ff & ~ev_s3_ff;
            default: sel_tick = (pre_ff & tap_mask) == tap_mask;
        endcase
    end

    assign eq = count_value_ff == compare_value_ff;
    assign match_evt = count_enable_ff & sel_tick & eq & ~mode_select_ff;

    always_ff @(posedge clk_i) begin
        if (reset_i || !count_enable_ff) begin
            count_value_ff <= RST_COUNT;
        end else if (sel_tick) begin
            if (!mode_select_ff && eq) begin
                count_value_ff <= RST_COUNT;
            end else begin
                count_value_ff <= count_value_ff + 8'h01;
            end
        end
    end

    // output flip-flops: square wave outside PWM, active phase in PWM
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            tff_ff <= 1'b0;
            pwm_act_ff <= 1'b0;
        end else begin
            if (wr_byte0 && wsel == SEL_CTRL && !mode_select_ff &&
                w_data_ff[CTRL_LVS_BIT] != w_data_ff[CTRL_LVR_BIT]) begin
                tff_ff <= w_data_ff[CTRL_LVS_BIT];
            end else if (match_evt && inv_ff) begin
                tff_ff <= ~tff_ff;
            end
            if (!count_enable_ff || !mode_select_ff) begin
                pwm_act_ff <= 1'b0;
            end else if (sel_tick && eq) begin
                pwm_act_ff <= 1'b0;
            end else if (sel_tick && count_value_ff == COUNT_TOP) begin
                pwm_act_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pin_ff <= 1'b0;
        end else begin
            pin_ff <= oe_ff & (mode_select_ff ? (pwm_act_ff ^ inv_ff) : tff_ff);
        end
    end

    // sticky status: a match in the clearing cycle wins over the clear
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sts_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            sts_ff <= (sts_ff & ~(wr_byte0 && wsel == SEL_STS && w_data_ff[STS_MATCH_BIT]))
                      | match_evt;
            irq_ff <= sts_ff & mask_ff;
        end
    end

    assign timer_out_pin_o = pin_ff;
    assign match_irq_o = irq_ff;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // checked at the first edge out of reset; an antecedent inside reset would be disabled
    a_cmp_reset_zero: assert property ($fell(reset_i) |-> compare_value_ff == 8'h00)
        else $error("compare value not zero after reset");
    a_clk_reset_zero: assert property ($fell(reset_i) |-> clk_sel_ff == 3'h0)
        else $error("clock select not zero after reset");
    a_clk_upper_zero: assert property (rvalid_ff && rsel_ff == SEL_CLK |-> rdata_ff[31:3] == 0)
        else $error("clock select upper bits read nonzero");
    a_cmp_full_write: assert property (wr_byte0 && wsel == SEL_CMP |=>
        compare_value_ff == $past(w_data_ff[7:0]))
        else $error("compare value write lost");
    a_cmp_byte_only: assert property (do_wr && !w_strb_ff[0] |=> $stable(compare_value_ff))
        else $error("compare value changed without low lane");
    a_match_sets_irq: assert property (count_enable_ff && sel_tick && eq && !mode_select_ff
        |=> sts_ff ##1 (irq_ff == $past(mask_ff)))
        else $error("match did not raise status");
    a_pwm_no_irq: assert property (mode_select_ff && !sts_ff |=> !sts_ff)
        else $error("pwm match raised status");
    a_pwm_inactive: assert property (mode_select_ff && count_enable_ff && sel_tick && eq
        |=> !pwm_act_ff ##1 (pin_ff == (oe_ff & inv_ff)))
        else $error("pwm match left output active");
    a_cnt_disable_clear: assert property (!count_enable_ff |=> count_value_ff == 8'h00)
        else $error("counter not cleared while disabled");
    a_cnt_step_one: assert property (count_enable_ff && sel_tick && !(eq && !mode_select_ff)
        |=> count_value_ff == $past(count_value_ff) + 8'h01)
        else $error("counter step wrong");
    a_div1_tap: assert property (clk_sel_ff == CODE_DIV1 |-> sel_tick)
        else $error("divide by one not every cycle");
    a_div2_tap: assert property (clk_sel_ff == CODE_DIV2 && sel_tick ##1
        clk_sel_ff == CODE_DIV2 |-> !sel_tick ##1 (clk_sel_ff != CODE_DIV2 || sel_tick))
        else $error("divide by two tap wrong");
    a_edge_one_cycle: assert property (clk_sel_ff <= CODE_RISE && sel_tick &&
        $stable(clk_sel_ff) |=> !sel_tick)
        else $error("edge pulse longer than one cycle");

    c_match_irq: cover property (match_evt ##2 irq_ff);
    c_pwm_cycle: cover property (pwm_act_ff ##[1:600] !pwm_act_ff);
    c_rise_tick: cover property (clk_sel_ff == CODE_RISE && sel_tick);
    c_cmp_write: cover property (wr_byte0 && wsel == SEL_CMP);
endmodule

// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import tmr_pkg::*;
    localparam logic [15:0] CS = IDX_CLKSEL0;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    tmr_axi_req_t req = '0;
    tmr_axi_rsp_t rsp;
    logic pin_in = 1'b0;
    logic pin_out;
    logic irq;
    int miscompares = 0;
    int n_compared = 0;
    int cyc = 0;

    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) cyc <= cyc + 1;

    tmr_timer8 #(.UNIT(0)) i_dut (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .axi_req_i(req),
        .axi_rsp_o(rsp),
        .event_in_pin_i(pin_in),
        .timer_out_pin_o(pin_out),
        .match_irq_o(irq)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // aw and w are offered together and each is dropped on its own handshake
    task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        int n;
        @(posedge clk_i);
        req.awvalid <= 1'b1;
        req.awaddr <= {idx, 2'b00};
        req.wvalid <= 1'b1;
        req.wdata <= {24'h0, d};
        req.wstrb <= s;
        req.bready <= 1'b1;
        r = 2'h3;
        for (n = 0; n < 100; n++) begin
            @(posedge clk_i);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (req.bready && rsp.bvalid) begin
                r = rsp.bresp;
                req.bready <= 1'b0;
                break;
            end
        end
        if (n == 100) chk(32'h0, 32'h1, "write hang");
    endtask

    task automatic w(input logic [15:0] idx, input logic [7:0] d);
        logic [1:0] r;
        wr(idx, d, 4'hf, r);
        chk(32'(r), 32'(RESP_OKAY), "bresp");
    endtask

    task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk_i);
        req.arvalid <= 1'b1;
        req.araddr <= {idx, 2'b00};
        req.rready <= 1'b1;
        d = 'x;
        r = 2'h3;
        for (n = 0; n < 100; n++) begin
            @(posedge clk_i);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (req.rready && rsp.rvalid) begin
                d = rsp.rdata;
                r = rsp.rresp;
                req.rready <= 1'b0;
                break;
            end
        end
        if (n == 100) chk(32'h0, 32'h1, "read hang");
    endtask

    task automatic rchk(input logic [15:0] idx, input logic [31:0] exp, input string msg);
        logic [31:0] d;
        logic [1:0] r;
        rd(idx, d, r);
        chk(d, exp, msg);
        chk(32'(r), 32'(RESP_OKAY), "rresp");
    endtask

    // irq is a level; wait for a fresh rise so a stale level is not counted
    task automatic wait_irq(output int t);
        int n;
        for (n = 0; n < 20000 && irq !== 1'b0; n++) @(posedge clk_i);
        for (n = 0; n < 20000 && irq !== 1'b1; n++) @(posedge clk_i);
        t = cyc;
        chk(32'(irq), 32'h1, "irq wait timeout");
    endtask

    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] vals[3] = '{8'h00, 8'hff, 8'ha5};
        rchk(CS, 32'h0, "clksel reset");
        rchk(IDX_CMP, 32'h0, "compare reset");
        foreach (vals[i]) begin
            w(IDX_CMP, vals[i]);
            rchk(IDX_CMP, {24'h0, vals[i]}, "compare range");
        end
        wr(IDX_CMP, 8'h3c, 4'h0, r);
        rchk(IDX_CMP, 32'ha5, "compare strobe off");
        w(CS, 8'hff);
        rchk(CS, 32'h7, "clksel upper bits");
        w(CS, 8'h05);
        rchk(CS, 32'h5, "clksel byte write");
        rd(16'h0001, d, r);
        chk(32'(r), 32'(RESP_SLVERR), "unmapped read resp");
        chk(d, 32'h0, "unmapped read data");
        wr(16'h0001, 8'h11, 4'hf, r);
        chk(32'(r), 32'(RESP_SLVERR), "unmapped write resp");
        w(CS, 8'h00);
        $display("test regs done");
    endtask

    task automatic t_clear_mode();
        w(CS, 8'(CODE_DIV1));
        w(IDX_CMP, 8'h03);
        w(IDX_MASK, 8'h00);
        w(IDX_CTRL, 8'h80);
        repeat (20) @(posedge clk_i);
        chk(32'(irq), 32'h0, "masked irq");
        rchk(IDX_STATUS, 32'h1, "match status");
        w(IDX_MASK, 8'h01);
        repeat (4) @(posedge clk_i);
        chk(32'(irq), 32'h1, "unmasked irq");
        w(IDX_CTRL, 8'h00);
        rchk(IDX_COUNT, 32'h0, "count cleared on disable");
        w(IDX_STATUS, 8'h01);
        rchk(IDX_STATUS, 32'h0, "status w1c");
        $display("test clear mode done");
    endtask

    // a clear-mode match recurs every compare + 1 count clocks; the divide-by-4 tap uses a longer compare
    task automatic t_dividers();
        int divs[4] = '{4, 64, 256, 8192};
        int cmps[4] = '{15, 1, 1, 1};
        int t1;
        int t2;
        foreach (divs[i]) begin
            w(IDX_CTRL, 8'h00);
            w(CS, 8'(4 + i));
            w(IDX_CMP, 8'(cmps[i]));
            w(IDX_MASK, 8'h01);
            w(IDX_STATUS, 8'h01);
            w(IDX_CTRL, 8'h80);
            wait_irq(t1);
            w(IDX_STATUS, 8'h01);
            wait_irq(t1);
            w(IDX_STATUS, 8'h01);
            wait_irq(t2);
            chk(32'(t2 - t1), 32'((cmps[i] + 1) * divs[i]), "match period");
        end
        w(IDX_CTRL, 8'h00);
        w(IDX_STATUS, 8'h01);
        $display("test dividers done");
    endtask

    task automatic t_event();
        for (int c = 1; c >= 0; c--) begin
            w(IDX_CTRL, 8'h00);
            w(CS, 8'(c));
            w(IDX_CMP, 8'hff);
            w(IDX_CTRL, 8'h80);
            repeat (3) begin
                repeat (8) @(posedge clk_i);
                pin_in <= 1'b1;
                repeat (8) @(posedge clk_i);
                pin_in <= 1'b0;
            end
            repeat (8) @(posedge clk_i);
            rchk(IDX_COUNT, 32'h3, "event edge count");
        end
        w(IDX_CTRL, 8'h00);
        $display("test event done");
    endtask

    task automatic t_pwm();
        int hi = 0;
        w(CS, 8'(CODE_DIV1));
        w(IDX_CMP, 8'h40);
        w(IDX_MASK, 8'h01);
        w(IDX_STATUS, 8'h01);
        w(IDX_CTRL, 8'hc1);
        repeat (300) @(posedge clk_i);
        for (int n = 0; n < 512; n++) begin
            @(posedge clk_i);
            if (pin_out === 1'b1) hi++;
        end
        chk(32'(hi), 32'(2 * (8'h40 + 1)), "pwm active cycles");
        chk(32'(irq), 32'h0, "no irq in pwm");
        rchk(IDX_STATUS, 32'h0, "no status in pwm");
        w(IDX_CTRL, 8'h00);
        $display("test pwm done");
    endtask

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (95000) @(posedge clk_i);
        miscompares++;
        print_verdict();
    end

    initial begin
        repeat (16) @(posedge clk_i);
        reset_i <= 1'b0;
        t_regs();
        t_clear_mode();
        t_event();
        t_pwm();
        t_dividers();
        print_verdict();
    end
endmodule
